// ==== design/dptc_corrector.sv ====
// Defect pixel table corrector: tables, storage sequencer and pixel replacement
//
// Functional notes
// - Replace listed pixels only while static correction is on; else pass through.
// - Method selector offers Average, Highlight and Zero for listed pixels.
// - Average replaces a listed pixel with the mean of its neighbours.
// - Highlight outputs the maximum pixel value for every listed pixel.
// - Entry total counts working entries; only entries below it are used.
// - Entry select picks which working entry coordinate accesses address.
// - Selected entry column reads back and accepts writes.
// - Selected entry row reads back and accepts writes.
// - Coordinates count from the full sensor origin, ignoring region offsets.
// - Coordinate edits leave images unchanged until commit.
// - Commit copies the whole working table into the active table.
// - Active table lives in volatile storage only.
// - Persist writes the table to storage, replacing the stored copy.
// - At power-up the stored table loads as working and active table.
// - Factory restore brings back the manufacturing calibrated list.
// - Factory restore replaces both active table and stored copy.
`timescale 1ns/10ps
`default_nettype none
`include "dptc_cfg.svh"
module dptc_corrector #(
  parameter int MAXE = `DPTC_MAX_ENTRIES,
  parameter int CW = `DPTC_COL_W,
  parameter int RW = `DPTC_ROW_W,
  parameter int PW = `DPTC_PIX_W,
  parameter int FDEPTH = `DPTC_FIFO_DEPTH,
  parameter int IW = $clog2(MAXE),
  parameter int TW = $clog2(MAXE + 1)
) (
  input wire logic clk_sys, // System clock, 10 MHz
  input wire logic reset, // Synchronous reset, active high
  input wire logic static_correction_on, // Correction enable
  input wire dptc_pkg::dptc_method_t replace_method, // Replacement method
  input wire logic [TW-1:0] entry_total_in, // New entry total
  input wire logic entry_total_wr, // Write strobe for entry total
  output logic [TW-1:0] entry_total, // Working entry total
  input wire logic [IW-1:0] entry_select, // Working entry selector
  input wire logic [CW-1:0] entry_column_in, // Column to write
  input wire logic entry_column_wr, // Column write strobe
  input wire logic [RW-1:0] entry_row_in, // Row to write
  input wire logic entry_row_wr, // Row write strobe
  output logic [CW-1:0] entry_column, // Selected entry column
  output logic [RW-1:0] entry_row, // Selected entry row
  input wire logic commit_table, // Commit command pulse
  input wire logic persist_table, // Persist command pulse
  input wire logic revert_to_calibration, // Factory restore pulse
  output logic table_busy, // Storage transfer in progress
  output logic swap_pending, // Committed table waits for frame start
  input wire logic pix_in_valid, // Input pixel valid
  output logic pix_in_ready, // Input pixel ready
  input wire logic [PW-1:0] pix_in_data, // Input pixel value
  input wire logic pix_in_sof, // First pixel of frame
  input wire logic pix_in_eol, // Last pixel of line
  output logic pix_out_valid, // Output pixel valid
  input wire logic pix_out_ready, // Output pixel ready
  output logic [PW-1:0] pix_out_data, // Output pixel value
  output logic pix_out_sof, // Output first pixel of frame
  output logic pix_out_eol, // Output last pixel of line
  output logic nv_req, // Storage request, held until ack
  output logic nv_we, // Storage write when high
  output logic [TW:0] nv_addr, // Storage address {region, word}
  output logic [RW+CW-1:0] nv_wdata, // Storage write data
  input wire logic [RW+CW-1:0] nv_rdata, // Storage read data, valid with ack
  input wire logic nv_ack // Storage acknowledge pulse
);
  import dptc_pkg::*;

  localparam int NW = RW + CW;
  localparam int FW = PW + 2;

  // Working, staged and active tables
  logic [CW-1:0] wk_col [MAXE];
  logic [RW-1:0] wk_row [MAXE];
  logic [TW-1:0] wk_total_q;
  logic [CW-1:0] stg_col [MAXE];
  logic [RW-1:0] stg_row [MAXE];
  logic [TW-1:0] stg_total_q;
  logic [CW-1:0] act_col [MAXE];
  logic [RW-1:0] act_row [MAXE];
  logic [TW-1:0] act_total_q;

  // Storage sequencer
  dptc_state_t st_q;
  logic [TW-1:0] wcnt_q;
  logic region_q;
  logic restore_q;
  logic load_done_q;
  logic busy_q;

  // Pixel path
  logic f_valid;
  logic f_ready;
  logic [FW-1:0] f_data;
  logic [PW-1:0] in_pix;
  logic in_sof;
  logic in_eol;
  logic [CW-1:0] col_cnt_q;
  logic [RW-1:0] row_cnt_q;
  logic [CW-1:0] in_col;
  logic [RW-1:0] in_row;
  logic [PW-1:0] ctr_q;
  logic [CW-1:0] ctr_col_q;
  logic [RW-1:0] ctr_row_q;
  logic ctr_valid_q;
  logic ctr_sof_q;
  logic ctr_eol_q;
  logic [PW-1:0] left_q;
  logic left_ok_q;
  logic can_emit;
  logic flush;
  logic accept;
  logic emit_go;
  logic hit;
  logic swap_now;
  logic stage_req;
  logic [TW-1:0] total_wr_val;

  function automatic logic [TW-1:0] clamp_total(input logic [TW-1:0] t);
    clamp_total = (t > TW'(MAXE)) ? TW'(MAXE) : t;
  endfunction : clamp_total

  // Storage word for a given word index of the working table
  function automatic logic [NW-1:0] nv_word(input logic [TW-1:0] idx);
    logic [IW-1:0] e;
    e = IW'(idx - 1'b1);
    if (idx == TW'(`DPTC_NV_TOTAL_WORD)) begin
      nv_word = NW'(wk_total_q);
    end else begin
      nv_word = {wk_row[e], wk_col[e]};
    end
  endfunction : nv_word

  // Replacement value of the centre pixel
  function automatic logic [PW-1:0] fix_pixel(input logic [PW-1:0] c, input logic [PW-1:0] l,
                                              input logic lok, input logic [PW-1:0] r,
                                              input logic rok, input logic listed,
                                              input logic on, input dptc_method_t m);
    logic [PW:0] sum;
    sum = {1'b0, l} + {1'b0, r};
    fix_pixel = c;
    if (on && listed) begin
      unique case (m)
        DPTC_HIGHLIGHT: fix_pixel = '1;
        DPTC_ZERO: fix_pixel = '0;
        default: begin
          if (lok && rok) begin
            fix_pixel = sum[PW:1];
          end else if (lok) begin
            fix_pixel = l;
          end else if (rok) begin
            fix_pixel = r;
          end
        end
      endcase
    end
  endfunction : fix_pixel

  assign total_wr_val = clamp_total(entry_total_in);
  assign entry_total = wk_total_q;
  assign table_busy = busy_q;

  // Working table: storage loads win; software edits are ignored while busy
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wk_total_q <= TW'(`DPTC_TOTAL_RST);
      for (int i = 0; i < MAXE; i++) begin
        wk_col[i] <= CW'(`DPTC_COORD_RST);
        wk_row[i] <= RW'(`DPTC_COORD_RST);
      end
    end else if (st_q == DPTC_READ && nv_req && nv_ack) begin
      if (wcnt_q == TW'(`DPTC_NV_TOTAL_WORD)) begin
        wk_total_q <= clamp_total(nv_rdata[TW-1:0]);
      end else begin
        wk_col[IW'(wcnt_q - 1'b1)] <= nv_rdata[CW-1:0];
        wk_row[IW'(wcnt_q - 1'b1)] <= nv_rdata[NW-1:CW];
      end
    end else if (!busy_q) begin
      if (entry_total_wr) begin
        wk_total_q <= total_wr_val;
      end
      if (entry_column_wr) begin
        wk_col[entry_select] <= entry_column_in;
      end
      if (entry_row_wr) begin
        wk_row[entry_select] <= entry_row_in;
      end
    end
  end

  // Readback of the selected working entry
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      entry_column <= '0;
      entry_row <= '0;
    end else begin
      entry_column <= wk_col[entry_select];
      entry_row <= wk_row[entry_select];
    end
  end

  // Staged copy; edits after commit do not reach it until the next commit
  assign stage_req = (commit_table && !busy_q) || load_done_q;
  assign swap_now = swap_pending && accept && in_sof;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      stg_total_q <= TW'(`DPTC_TOTAL_RST);
      swap_pending <= 1'b0;
      for (int i = 0; i < MAXE; i++) begin
        stg_col[i] <= CW'(`DPTC_COORD_RST);
        stg_row[i] <= RW'(`DPTC_COORD_RST);
      end
    end else if (stage_req) begin
      // A new commit beats a swap in the same cycle, so it stays pending
      stg_total_q <= wk_total_q;
      swap_pending <= 1'b1;
      for (int i = 0; i < MAXE; i++) begin
        stg_col[i] <= wk_col[i];
        stg_row[i] <= wk_row[i];
      end
    end else if (swap_now) begin
      swap_pending <= 1'b0;
    end
  end

  // Active table, cleared at reset: nothing of it survives power loss
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      act_total_q <= TW'(`DPTC_TOTAL_RST);
      for (int i = 0; i < MAXE; i++) begin
        act_col[i] <= CW'(`DPTC_COORD_RST);
        act_row[i] <= RW'(`DPTC_COORD_RST);
      end
    end else if (swap_now) begin
      act_total_q <= stg_total_q;
      for (int i = 0; i < MAXE; i++) begin
        act_col[i] <= stg_col[i];
        act_row[i] <= stg_row[i];
      end
    end
  end

  // Storage sequencer: boot load, persist, factory restore
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_q <= DPTC_READ;
      region_q <= `DPTC_NV_USER;
      wcnt_q <= '0;
      restore_q <= 1'b0;
      busy_q <= 1'b1;
      load_done_q <= 1'b0;
      nv_req <= 1'b0;
      nv_we <= 1'b0;
      nv_addr <= '0;
      nv_wdata <= '0;
    end else begin
      load_done_q <= 1'b0;
      unique case (st_q)
        DPTC_IDLE: begin
          if (revert_to_calibration) begin
            st_q <= DPTC_READ;
            region_q <= `DPTC_NV_FACTORY;
            restore_q <= 1'b1;
            wcnt_q <= '0;
            busy_q <= 1'b1;
          end else if (persist_table) begin
            st_q <= DPTC_WRITE;
            region_q <= `DPTC_NV_USER;
            wcnt_q <= '0;
            busy_q <= 1'b1;
          end
        end
        DPTC_READ: begin
          if (!nv_req) begin
            nv_req <= 1'b1;
            nv_we <= 1'b0;
            nv_addr <= {region_q, wcnt_q};
          end else if (nv_ack) begin
            nv_req <= 1'b0;
            if (wcnt_q == TW'(MAXE)) begin
              load_done_q <= 1'b1;
              wcnt_q <= '0;
              if (restore_q) begin
                st_q <= DPTC_WRITE;
                region_q <= `DPTC_NV_USER;
              end else begin
                st_q <= DPTC_IDLE;
                busy_q <= 1'b0;
              end
            end else begin
              wcnt_q <= TW'(wcnt_q + 1'b1);
            end
          end
        end
        DPTC_WRITE: begin
          if (!nv_req) begin
            nv_req <= 1'b1;
            nv_we <= 1'b1;
            nv_addr <= {region_q, wcnt_q};
            nv_wdata <= nv_word(wcnt_q);
          end else if (nv_ack) begin
            nv_req <= 1'b0;
            nv_we <= 1'b0;
            if (wcnt_q == TW'(MAXE)) begin
              st_q <= DPTC_IDLE;
              busy_q <= 1'b0;
              restore_q <= 1'b0;
              wcnt_q <= '0;
            end else begin
              wcnt_q <= TW'(wcnt_q + 1'b1);
            end
          end
        end
      endcase
    end
  end

  // Input buffering
  dptc_fifo #(
    .W(FW),
    .DEPTH(FDEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .reset(reset),
    .in_valid(pix_in_valid),
    .in_ready(pix_in_ready),
    .in_data({pix_in_sof, pix_in_eol, pix_in_data}),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  assign in_pix = f_data[PW-1:0];
  assign in_eol = f_data[PW];
  assign in_sof = f_data[PW+1];

  // Centre pixel leaves when its right neighbour arrives or its line ends
  assign can_emit = !pix_out_valid || pix_out_ready;
  assign flush = ctr_valid_q && ctr_eol_q;
  assign f_ready = can_emit && !flush;
  assign accept = f_valid && f_ready;
  assign emit_go = can_emit && ctr_valid_q && (ctr_eol_q || f_valid);

  // Position from frame start, so the origin is the full sensor corner
  assign in_col = in_sof ? '0 : col_cnt_q;
  assign in_row = in_sof ? '0 : row_cnt_q;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      col_cnt_q <= '0;
      row_cnt_q <= '0;
    end else if (accept) begin
      if (in_eol) begin
        col_cnt_q <= '0;
        row_cnt_q <= RW'(in_row + 1'b1);
      end else begin
        col_cnt_q <= CW'(in_col + 1'b1);
        row_cnt_q <= in_row;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctr_q <= '0;
      ctr_col_q <= '0;
      ctr_row_q <= '0;
      ctr_valid_q <= 1'b0;
      ctr_sof_q <= 1'b0;
      ctr_eol_q <= 1'b0;
      left_q <= '0;
      left_ok_q <= 1'b0;
    end else if (flush && emit_go) begin
      ctr_valid_q <= 1'b0;
      left_ok_q <= 1'b0;
    end else if (accept) begin
      // Neighbours never cross a line or frame edge
      left_q <= ctr_q;
      left_ok_q <= ctr_valid_q && !in_sof;
      ctr_q <= in_pix;
      ctr_col_q <= in_col;
      ctr_row_q <= in_row;
      ctr_valid_q <= 1'b1;
      ctr_sof_q <= in_sof;
      ctr_eol_q <= in_eol;
    end
  end

  dptc_match #(
    .N(MAXE),
    .CW(CW),
    .RW(RW),
    .TW(TW)
  ) u_match (
    .col(ctr_col_q),
    .row(ctr_row_q),
    .tab_col(act_col),
    .tab_row(act_row),
    .total(act_total_q),
    .hit(hit)
  );

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pix_out_valid <= 1'b0;
      pix_out_data <= '0;
      pix_out_sof <= 1'b0;
      pix_out_eol <= 1'b0;
    end else if (emit_go) begin
      pix_out_valid <= 1'b1;
      pix_out_data <= fix_pixel(ctr_q, left_q, left_ok_q, in_pix, !ctr_eol_q, hit,
                                static_correction_on, replace_method);
      pix_out_sof <= ctr_sof_q;
      pix_out_eol <= ctr_eol_q;
    end else if (pix_out_ready) begin
      pix_out_valid <= 1'b0;
    end
  end
endmodule : dptc_corrector
`default_nettype wire

// ==== design/dptc_fifo.sv ====
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module dptc_fifo #(
  parameter int W = 14,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys, // System clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic in_valid, // Write side valid
  output logic in_ready, // Write side ready, registered
  input wire logic [W-1:0] in_data, // Write data
  output logic out_valid, // Read side valid
  input wire logic out_ready, // Read side ready
  output logic [W-1:0] out_data // Read data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_q;
  logic [AW-1:0] rptr_q;
  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (count_q != '0);
  assign out_data = mem[rptr_q];

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction : ptr_inc

  always_comb begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = CW'(count_q + 1'b1);
    end else if (pop && !push) begin
      count_d = CW'(count_q - 1'b1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wptr_q <= '0;
      rptr_q <= '0;
      count_q <= '0;
      in_ready <= 1'b0;
    end else begin
      if (push) begin
        wptr_q <= ptr_inc(wptr_q);
      end
      if (pop) begin
        rptr_q <= ptr_inc(rptr_q);
      end
      count_q <= count_d;
      // Registered ready from the next count, so a full FIFO stalls the source until the cycle after a pop
      in_ready <= (count_d < CW'(DEPTH));
    end
  end
endmodule : dptc_fifo
`default_nettype wire

// ==== design/dptc_match.sv ====
// Coordinate lookup against the active defect table
`timescale 1ns/10ps
`default_nettype none
module dptc_match #(
  parameter int N = 16,
  parameter int CW = 12,
  parameter int RW = 12,
  parameter int TW = 5
) (
  input wire logic [CW-1:0] col, // Column of the pixel under test
  input wire logic [RW-1:0] row, // Row of the pixel under test
  input wire logic [CW-1:0] tab_col [N], // Active table columns
  input wire logic [RW-1:0] tab_row [N], // Active table rows
  input wire logic [TW-1:0] total, // Entries in use
  output logic hit // Pixel is listed
);
  always_comb begin
    hit = 1'b0;
    for (int i = 0; i < N; i++) begin
      // Entries at or above the total never match
      if ((TW'(i) < total) && (tab_col[i] == col) && (tab_row[i] == row)) begin
        hit = 1'b1;
      end
    end
  end
endmodule : dptc_match
`default_nettype wire

// ==== inc/dptc_cfg.svh ====
// Constants of the defect pixel table corrector: sizes, storage layout, reset values
`ifndef DPTC_CFG_SVH
`define DPTC_CFG_SVH

`define DPTC_MAX_ENTRIES 16
`define DPTC_COL_W 12
`define DPTC_ROW_W 12
`define DPTC_PIX_W 12
`define DPTC_FIFO_DEPTH 16

// Storage regions; each region holds the total at word 0, then one word per entry
`define DPTC_NV_USER 1'b0
`define DPTC_NV_FACTORY 1'b1
`define DPTC_NV_TOTAL_WORD 0

// Reset values
`define DPTC_TOTAL_RST 0
`define DPTC_COORD_RST 0

`endif

// ==== inc/dptc_pkg.sv ====
// Types of the defect pixel table corrector
`default_nettype none
package dptc_pkg;

  // Replacement method selector
  typedef enum logic [1:0] {
    DPTC_AVERAGE = 2'h0,
    DPTC_HIGHLIGHT = 2'h1,
    DPTC_ZERO = 2'h2
  } dptc_method_t;

  // Storage sequencer, Gray coded along idle, read, write
  typedef enum logic [1:0] {
    DPTC_IDLE = 2'h0,
    DPTC_READ = 2'h1,
    DPTC_WRITE = 2'h3
  } dptc_state_t;

endpackage : dptc_pkg
`default_nettype wire

// ==== test/dptc_corrector_assertions.sv ====
// Checker of storage handshake, reset and command responses
`timescale 1ns/10ps
`default_nettype none
module dptc_corrector_checker #(
  parameter int TW = 5
) (
  input wire logic clk_sys, // Clock
  input wire logic reset, // Reset
  input wire logic commit_table, // Commit
  input wire logic persist_table, // Persist
  input wire logic revert_to_calibration, // Restore
  input wire logic table_busy, // Busy
  input wire logic swap_pending, // Pending
  input wire logic [TW-1:0] entry_total_in, // Total in
  input wire logic entry_total_wr, // Total strobe
  input wire logic [TW-1:0] entry_total, // Total
  input wire logic pix_out_valid, // Out valid
  input wire logic pix_out_ready, // Out ready
  input wire logic [11:0] pix_out_data, // Out data
  input wire logic nv_req, // Storage request
  input wire logic nv_we, // Storage write
  input wire logic [TW:0] nv_addr, // Storage address
  input wire logic nv_ack // Storage ack
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  AST_NV_HOLD: assert property (nv_req && !nv_ack
    |=> nv_req && $stable(nv_addr) && $stable(nv_we))
    else $error("storage request changed before ack");
  AST_NV_DROP: assert property (nv_req && nv_ack |=> !nv_req)
    else $error("storage request not dropped after ack");
  AST_BOOT_LOAD: assert property ($fell(reset)
    |-> ##[0:2] (nv_req && !nv_we && nv_addr == 6'h00))
    else $error("no boot read of stored total");
  AST_BUSY_BOOT: assert property ($fell(reset) |-> table_busy)
    else $error("not busy after reset");
  AST_OUT_HOLD: assert property (pix_out_valid && !pix_out_ready
    |=> pix_out_valid && $stable(pix_out_data))
    else $error("output pixel dropped under stall");
  AST_TOTAL: assert property (entry_total_wr && !table_busy && entry_total_in <= 5'h10
    |=> entry_total == $past(entry_total_in))
    else $error("entry total not taken");
  AST_COMMIT: assert property (commit_table && !table_busy |=> swap_pending)
    else $error("commit not staged");
  AST_PERSIST: assert property (persist_table && !revert_to_calibration && !table_busy
    |-> ##[1:3] (nv_req && nv_we && !nv_addr[TW]))
    else $error("persist wrote no user word");
  AST_REVERT: assert property (revert_to_calibration && !table_busy
    |-> ##[1:3] (nv_req && !nv_we && nv_addr[TW]))
    else $error("restore read no factory word");
  cover property (commit_table && !table_busy);
  cover property (revert_to_calibration && !table_busy);
  cover property (pix_out_valid && !pix_out_ready);
endmodule : dptc_corrector_checker
bind dptc_corrector dptc_corrector_checker #(.TW(TW)) dptc_corrector_checker_inst (.clk_sys,
  .reset, .commit_table, .persist_table, .revert_to_calibration, .table_busy, .swap_pending,
  .entry_total_in, .entry_total_wr, .entry_total, .pix_out_valid, .pix_out_ready, .pix_out_data,
  .nv_req, .nv_we, .nv_addr, .nv_ack);
`default_nettype wire

// ==== test/dptc_nv_model.sv ====
// Non-volatile table storage with user and factory regions
`timescale 1ns/10ps
`default_nettype none
module dptc_nv_model (
  input wire logic clk_sys, // Clock
  input wire logic reset, // Reset
  input wire logic nv_req, // Request
  input wire logic nv_we, // Write
  input wire logic [5:0] nv_addr, // Address
  input wire logic [23:0] nv_wdata, // Write data
  input wire logic [3:0] dly, // Answer delay in cycles
  output logic [23:0] nv_rdata, // Read data
  output logic nv_ack // Acknowledge pulse
);
  logic [23:0] mem [64];
  logic [3:0] cnt;
  initial begin
    foreach (mem[i]) mem[i] = 24'h000000;
    mem[0] = 24'h000001;
    mem[1] = 24'h000002;
    mem[32] = 24'h000002;
    mem[33] = 24'h000001;
    mem[34] = 24'h001003;
    nv_rdata = 24'h000000;
    nv_ack = 1'b0;
    cnt = 4'h0;
  end
  // Stale read data flips every cycle so it is never mistaken for a hit
  always @(posedge clk_sys) begin
    nv_ack <= 1'b0;
    nv_rdata <= ~nv_rdata;
    if (reset) begin
      cnt <= 4'h0;
    end else if (nv_req && !nv_ack) begin
      if (cnt >= dly) begin
        nv_ack <= 1'b1;
        cnt <= 4'h0;
        if (nv_we) mem[nv_addr] <= nv_wdata;
        else nv_rdata <= mem[nv_addr];
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule : dptc_nv_model
`default_nettype wire

// ==== test/tb_dptc_corrector.sv ====
// Testbench of the defect pixel table corrector
`timescale 1ns/10ps
`default_nettype none
module tb_dptc_corrector;
  import dptc_pkg::*;
  logic clk_sys = 1'b0, reset = 1'b1, static_correction_on = 1'b0;
  dptc_method_t replace_method = DPTC_AVERAGE;
  logic [4:0] entry_total_in = 5'h00, entry_total;
  logic [3:0] entry_select = 4'h0, dly = 4'h0;
  logic [11:0] entry_column_in = 12'h000, entry_row_in = 12'h000, pix_in_data = 12'h000;
  logic entry_total_wr = 1'b0, entry_column_wr = 1'b0, entry_row_wr = 1'b0;
  logic commit_table = 1'b0, persist_table = 1'b0, revert_to_calibration = 1'b0;
  logic pix_in_valid = 1'b0, pix_in_sof = 1'b0, pix_in_eol = 1'b0, pix_out_ready = 1'b1;
  logic [11:0] entry_column, entry_row, pix_out_data;
  logic table_busy, swap_pending, pix_in_ready, pix_out_valid, pix_out_sof, pix_out_eol;
  logic nv_req, nv_we, nv_ack;
  logic [5:0] nv_addr;
  logic [23:0] nv_wdata, nv_rdata;
  int err_count = 0, n_checks = 0, an = 0;
  int ac[4], ar[4];
  logic [13:0] rx_q[$];
  always #50 clk_sys = ~clk_sys;
  dptc_corrector dptc_corrector_inst (.clk_sys, .reset, .static_correction_on, .replace_method,
    .entry_total_in, .entry_total_wr, .entry_total, .entry_select, .entry_column_in,
    .entry_column_wr, .entry_row_in, .entry_row_wr, .entry_column, .entry_row, .commit_table,
    .persist_table, .revert_to_calibration, .table_busy, .swap_pending, .pix_in_valid,
    .pix_in_ready, .pix_in_data, .pix_in_sof, .pix_in_eol, .pix_out_valid, .pix_out_ready,
    .pix_out_data, .pix_out_sof, .pix_out_eol, .nv_req, .nv_we, .nv_addr, .nv_wdata,
    .nv_rdata, .nv_ack);
  dptc_nv_model dptc_nv_model_inst (.clk_sys, .reset, .nv_req, .nv_we, .nv_addr, .nv_wdata,
    .dly, .nv_rdata, .nv_ack);
  // Output stream kept as {sof, eol, pixel}
  always @(posedge clk_sys) begin
    if (pix_out_valid === 1'b1 && pix_out_ready) begin
      rx_q.push_back({pix_out_sof, pix_out_eol, pix_out_data});
    end
  end
  task automatic chk(string what, logic [23:0] exp, logic [23:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Squared column term so a neighbour mean differs from the original
  function automatic logic [11:0] pv(int r, int c);
    return 12'(64 + c * c * 32 + r * 768);
  endfunction : pv
  function automatic logic [11:0] ev(int r, int c, logic en, dptc_method_t m);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < an; i++) if (ac[i] == c && ar[i] == r) hit = 1'b1;
    if (!en || !hit) return pv(r, c);
    if (m == DPTC_HIGHLIGHT) return 12'hFFF;
    if (m == DPTC_ZERO) return 12'h000;
    if (c == 0) return pv(r, 1);
    if (c == 3) return pv(r, 2);
    return 12'((pv(r, c - 1) + pv(r, c + 1)) >> 1);
  endfunction : ev
  task automatic frame(string name, logic en, dptc_method_t m, logic stall);
    @(posedge clk_sys);
    static_correction_on <= en;
    replace_method <= m;
    pix_out_ready <= !stall;
    rx_q.delete();
    for (int k = 0; k < 8; k++) begin
      pix_in_valid <= 1'b1;
      pix_in_data <= pv(k / 4, k % 4);
      pix_in_sof <= (k == 0);
      pix_in_eol <= (k % 4 == 3);
      do @(negedge clk_sys); while (pix_in_ready !== 1'b1);
      @(posedge clk_sys);
    end
    pix_in_valid <= 1'b0;
    pix_out_ready <= 1'b1;
    for (int i = 0; i < 100 && rx_q.size() < 8; i++) @(posedge clk_sys);
    chk("pixel count", 24'd8, 24'(rx_q.size()));
    for (int k = 0; k < 8 && k < rx_q.size(); k++) begin
      chk(name, {10'h000, k == 0, k % 4 == 3, ev(k / 4, k % 4, en, m)}, 24'(rx_q[k]));
    end
    $display("frame %s done", name);
  endtask : frame
  task automatic idle;
    for (int i = 0; i < 900 && table_busy !== 1'b0; i++) @(posedge clk_sys);
    chk("busy", 24'h0, 24'(table_busy));
  endtask : idle
  task automatic cmd(int k);
    @(posedge clk_sys);
    commit_table <= (k == 0);
    persist_table <= (k == 1);
    revert_to_calibration <= (k == 2);
    @(posedge clk_sys);
    {commit_table, persist_table, revert_to_calibration} <= 3'h0;
    repeat (2) @(posedge clk_sys);
    idle();
  endtask : cmd
  task automatic entry(logic w, int s, int c, int r);
    @(posedge clk_sys);
    entry_select <= 4'(s);
    entry_column_in <= 12'(c);
    entry_row_in <= 12'(r);
    entry_column_wr <= w;
    entry_row_wr <= w;
    @(posedge clk_sys);
    {entry_column_wr, entry_row_wr} <= 2'h0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("column", 24'(c), 24'(entry_column));
    chk("row", 24'(r), 24'(entry_row));
  endtask : entry
  task automatic set_total(int n);
    @(posedge clk_sys);
    entry_total_in <= 5'(n);
    entry_total_wr <= 1'b1;
    @(posedge clk_sys);
    entry_total_wr <= 1'b0;
    @(negedge clk_sys);
    chk("total", 24'(n), 24'(entry_total));
  endtask : set_total
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    test_done();
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (2) @(posedge clk_sys);
    idle();
    chk("boot total", 24'h1, 24'(entry_total));
    entry(1'b0, 0, 2, 0);
    an = 1; ac[0] = 2; ar[0] = 0;
    frame("boot zero", 1'b1, DPTC_ZERO, 1'b0);
    frame("average", 1'b1, DPTC_AVERAGE, 1'b0);
    frame("highlight", 1'b1, DPTC_HIGHLIGHT, 1'b1);
    frame("off", 1'b0, DPTC_HIGHLIGHT, 1'b0);
    set_total(2);
    entry(1'b1, 1, 0, 1);
    entry(1'b1, 2, 3, 1);
    frame("before commit", 1'b1, DPTC_AVERAGE, 1'b0);
    cmd(0);
    chk("staged", 24'h1, 24'(swap_pending));
    an = 2; ac[1] = 0; ar[1] = 1;
    frame("committed", 1'b1, DPTC_AVERAGE, 1'b0);
    chk("swapped", 24'h0, 24'(swap_pending));
    cmd(1);
    chk("saved total", 24'h2, dptc_nv_model_inst.mem[0]);
    chk("saved entry", 24'h001000, dptc_nv_model_inst.mem[2]);
    dly <= 4'h3;
    cmd(2);
    chk("factory total", 24'h2, 24'(entry_total));
    entry(1'b0, 1, 3, 1);
    chk("stored copy", 24'h000001, dptc_nv_model_inst.mem[1]);
    ac[0] = 1; ar[0] = 0; ac[1] = 3; ar[1] = 1;
    frame("factory", 1'b1, DPTC_ZERO, 1'b0);
    // Committed but unsaved edit must not survive a reset
    entry(1'b1, 0, 2, 0);
    cmd(0);
    reset <= 1'b1;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (2) @(posedge clk_sys);
    idle();
    entry(1'b0, 0, 1, 0);
    $display("reset reload done");
    test_done();
  end
endmodule : tb_dptc_corrector
`default_nettype wire
